// ==== core/dmdu_pkg.sv ====
package dmdu_pkg;
  // ----------------------------------------------------------------
  // register window
  // ----------------------------------------------------------------
  localparam logic [7:0] SYSCTL_OFS = 8'h00;
  localparam logic [7:0] CMD_BASE_OFS = 8'h40;
  localparam logic [7:0] CMD_LAST_OFS = 8'hBC;
  localparam int SC_MODE_BIT = 0;
  localparam int SC_ODDEVEN_BIT = 1;
  localparam int SC_CH3_EN_BIT = 2;
  localparam logic [2:0] SYSCTL_RST = 3'h0;
  // ----------------------------------------------------------------
  // command indices, full-featured mode
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_INIT = 4'h0;
  localparam logic [3:0] CMD_CHAN = 4'h1;
  localparam logic [3:0] CMD_COUNT = 4'h2;
  localparam logic [3:0] CMD_ADDR = 4'h4;
  localparam logic [3:0] CMD_DEVCTL = 4'h8;
  localparam logic [3:0] CMD_MODE = 4'hA;
  localparam logic [3:0] CMD_STATUS = 4'hB;
  localparam logic [3:0] CMD_MASK = 4'hF;
  // ----------------------------------------------------------------
  // command indices, legacy-compatible mode
  // ----------------------------------------------------------------
  localparam logic [3:0] LCMD_STATUS = 4'h8;
  localparam logic [3:0] LCMD_REQ = 4'h9;
  localparam logic [3:0] LCMD_MODE = 4'hB;
  localparam logic [3:0] LCMD_MASK = 4'hF;
  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CHAN_BASE_BIT = 2;
  localparam int INIT_RES_BIT = 0;
  localparam int REQ_SET_BIT = 2;
  localparam logic [1:0] DIR_IO_TO_MEM = 2'h1;
  localparam logic [1:0] DIR_MEM_TO_IO = 2'h2;
  localparam logic [3:0] MASK_RST = 4'hF;
  localparam logic [3:0] CH_ENABLE_LOW3 = 4'h7;
  localparam logic [19:0] ADDR_STEP_BYTE = 20'h00001;
  localparam logic [19:0] ADDR_STEP_WORD = 20'h00002;

  typedef struct packed {
    logic decrement;
    logic autoinit;
    logic [1:0] dir;
    logic word;
  } dmdu_mode_s;

  typedef struct packed {
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic memory_read_strobe_n;
    logic memory_write_strobe_n;
  } dmdu_strobe_s;

  localparam dmdu_strobe_s STROBE_IDLE = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_T1 = 3'b001,
    ST_T2 = 3'b010,
    ST_T3 = 3'b011,
    ST_TW = 3'b100,
    ST_T4 = 3'b101,
    ST_RWAIT = 3'b110
  } dmdu_state_e;
endpackage : dmdu_pkg

// ==== core/dmdu_top.sv ====
`timescale 1ns/1ps
// Contract
// - mode switch keeps every register value, unused bits included
// - channel-select only in full mode, request register only in legacy mode
// - full mode byte or word transfers; legacy mode bytes only
// - legacy mode-control write takes its channel from the written data
// - legacy address/count access takes its channel from the I/O address
// - full mode: read current, write both, base option touches base only
// - legacy reads return current, writes load base and current
// - legacy request register write raises a software request
// - full mode selects bus release or hold; legacy always releases
// - full mode contiguous addresses; legacy may pick odd/even placement
// - serving: take bus, acknowledge winner, drive address and strobes
// - no bus takeover while another master owns the bus
// - idle: sample requests every clock into status; channel 3 configurable
// - valid request raises bus request, sampling continues until grant
// - on grant freeze sampling, pick highest priority, assert its acknowledge
// - programming accepted only in idle, decoded from four command bits
// - a transfer cycle lasts four clocks without waits
// - waits follow the third state; terminal count and acknowledge hold
// - io-to-memory: io read, memory write; memory-to-io: memory read, io write
// - refresh request during a cycle may put the unit in bus wait
// - count decrements per transfer; borrow gives terminal count, count plus one
// - mode bit 0 set selects legacy mode; full mode, with the bit clear, is active after reset
module dmdu_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [3:0] channel_request_in,
  output logic [3:0] channel_acknowledge_out_n,
  input wire logic ready_in,
  output logic internal_bus_request,
  input wire logic internal_bus_grant,
  input wire logic refresh_request,
  output logic terminal_count_out_n,
  output dmdu_pkg::dmdu_strobe_s strobes,
  output logic [19:0] mem_address_out,
  output logic word_transfer_out
);
  // ----------------------------------------------------------------
  // pin synchronisers: requests and ready
  // ----------------------------------------------------------------
  logic [4:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_next;

  always_comb begin
    // a bit moves only once the second and third stages agree
    filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      sync3_reg <= 5'h00;
      filt_reg <= 5'h00;
    end else begin
      sync1_reg <= {ready_in, channel_request_in};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
    end
  end

  wire [3:0] req_pins = filt_reg[3:0];
  wire ready_pin = filt_reg[4];

  // ----------------------------------------------------------------
  // AHB-Lite slave: at least one wait state per transfer, more while a transfer runs
  // ----------------------------------------------------------------
  logic pend_reg, pend_next, ack_reg, ack_next, wr_reg, wr_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic [31:0] rd_val;
  logic acc;
  dmdu_pkg::dmdu_state_e st_reg, st_next;

  wire take = hsel & hready & htrans[1];
  // the access waits for the idle cycle, so programming never races a transfer
  assign acc = pend_reg & ~ack_reg & (st_reg == dmdu_pkg::ST_IDLE);

  always_comb begin
    pend_next = pend_reg;
    ack_next = ack_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    hrdata_next = hrdata_reg;
    if (acc) begin
      ack_next = 1'b1;
      hrdata_next = wr_reg ? 32'h00000000 : rd_val;
    end
    if (pend_reg & ack_reg) begin
      pend_next = 1'b0;
      ack_next = 1'b0;
    end
    if (take & hreadyout) begin
      pend_next = 1'b1;
      ack_next = 1'b0;
      wr_next = hwrite;
      addr_next = haddr[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_reg <= 1'b0;
      ack_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h00000000;
    end else begin
      pend_reg <= pend_next;
      ack_reg <= ack_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  assign hreadyout = ~pend_reg | ack_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic [2:0] sysctl_reg, sysctl_next;
  wire legacy = sysctl_reg[dmdu_pkg::SC_MODE_BIT];
  wire oddeven = legacy & sysctl_reg[dmdu_pkg::SC_ODDEVEN_BIT];
  wire [5:0] widx = addr_reg[7:2];
  wire [5:0] cmd_word = widx - 6'h10;
  wire in_cmd = (addr_reg >= dmdu_pkg::CMD_BASE_OFS) && (addr_reg <= dmdu_pkg::CMD_LAST_OFS);
  logic cmd_hit;
  logic [3:0] cmd;

  always_comb begin
    cmd = cmd_word[3:0];
    cmd_hit = in_cmd & ~cmd_word[4];
    if (oddeven) begin
      // odd/even placement spreads the commands over every other word
      cmd = cmd_word[4:1];
      cmd_hit = in_cmd & ~cmd_word[0];
    end
  end

  // ----------------------------------------------------------------
  // channel registers
  // ----------------------------------------------------------------
  logic [19:0] base_addr_reg [4];
  logic [19:0] base_addr_next [4];
  logic [19:0] cur_addr_reg [4];
  logic [19:0] cur_addr_next [4];
  logic [15:0] base_cnt_reg [4];
  logic [15:0] base_cnt_next [4];
  logic [15:0] cur_cnt_reg [4];
  logic [15:0] cur_cnt_next [4];
  dmdu_pkg::dmdu_mode_s mode_reg [4];
  dmdu_pkg::dmdu_mode_s mode_next [4];
  logic [1:0] chan_reg, chan_next;
  logic base_only_reg, base_only_next;
  logic bus_hold_reg, bus_hold_next;
  logic [3:0] tcflag_reg, tcflag_next;
  logic [3:0] sample_reg, sample_next;
  logic [3:0] mask_reg, mask_next;
  logic [3:0] swreq_reg, swreq_next;
  logic [1:0] act_reg, act_next;
  logic xfer_end, last_xfer;

  wire [1:0] lch = cmd[2:1];
  wire [1:0] dch = hwdata[1:0];
  wire dsel_full = acc & cmd_hit & ~legacy;
  wire dsel_leg = acc & cmd_hit & legacy;
  wire sys_sel = acc & (addr_reg == dmdu_pkg::SYSCTL_OFS);

  always_comb begin
    rd_val = 32'h00000000;
    if (addr_reg == dmdu_pkg::SYSCTL_OFS) begin
      rd_val = {29'h0, sysctl_reg};
    end else if (cmd_hit & ~legacy) begin
      case (cmd)
        dmdu_pkg::CMD_CHAN: rd_val = {27'h0, base_only_reg, 4'h1 << chan_reg};
        dmdu_pkg::CMD_COUNT: rd_val = {16'h0, base_only_reg ? base_cnt_reg[chan_reg] : cur_cnt_reg[chan_reg]};
        dmdu_pkg::CMD_ADDR: rd_val = {12'h0, base_only_reg ? base_addr_reg[chan_reg] : cur_addr_reg[chan_reg]};
        dmdu_pkg::CMD_DEVCTL: rd_val = {31'h0, bus_hold_reg};
        dmdu_pkg::CMD_MODE: rd_val = {26'h0, mode_reg[chan_reg][4:1], 1'b0, mode_reg[chan_reg][0]};
        dmdu_pkg::CMD_STATUS: rd_val = {24'h0, sample_reg, tcflag_reg};
        dmdu_pkg::CMD_MASK: rd_val = {28'h0, mask_reg};
        default: rd_val = 32'h00000000;
      endcase
    end else if (cmd_hit & legacy) begin
      if (~cmd[3]) begin
        // channel from the command address, current value only
        rd_val = cmd[0] ? {16'h0, cur_cnt_reg[lch]} : {12'h0, cur_addr_reg[lch]};
      end else begin
        case (cmd)
          dmdu_pkg::LCMD_STATUS: rd_val = {24'h0, sample_reg, tcflag_reg};
          dmdu_pkg::LCMD_REQ: rd_val = {28'h0, swreq_reg};
          dmdu_pkg::LCMD_MASK: rd_val = {28'h0, mask_reg};
          default: rd_val = 32'h00000000;
        endcase
      end
    end
  end

  wire init_cmd = dsel_full & wr_reg & (cmd == dmdu_pkg::CMD_INIT) & hwdata[dmdu_pkg::INIT_RES_BIT];
  wire st_rd = acc & cmd_hit & ~wr_reg & (cmd == (legacy ? dmdu_pkg::LCMD_STATUS : dmdu_pkg::CMD_STATUS));
  wire [3:0] act_oh = 4'h1 << act_reg;
  wire [19:0] step = mode_reg[act_reg].word & ~legacy ? dmdu_pkg::ADDR_STEP_WORD : dmdu_pkg::ADDR_STEP_BYTE;

  always_comb begin
    sysctl_next = sysctl_reg;
    chan_next = chan_reg;
    base_only_next = base_only_reg;
    bus_hold_next = bus_hold_reg;
    tcflag_next = tcflag_reg;
    mask_next = mask_reg;
    swreq_next = swreq_reg;
    for (int i = 0; i < 4; i++) begin
      base_addr_next[i] = base_addr_reg[i];
      cur_addr_next[i] = cur_addr_reg[i];
      base_cnt_next[i] = base_cnt_reg[i];
      cur_cnt_next[i] = cur_cnt_reg[i];
      mode_next[i] = mode_reg[i];
    end
    // mode switch touches nothing else, so every other field survives
    if (sys_sel & wr_reg) begin
      sysctl_next = hwdata[2:0];
    end
    if (st_rd) begin
      tcflag_next = 4'h0;
    end
    if (dsel_full & wr_reg) begin
      case (cmd)
        dmdu_pkg::CMD_CHAN: begin
          chan_next = dch;
          base_only_next = hwdata[dmdu_pkg::CHAN_BASE_BIT];
        end
        dmdu_pkg::CMD_COUNT: begin
          base_cnt_next[chan_reg] = hwdata[15:0];
          if (~base_only_reg) begin
            cur_cnt_next[chan_reg] = hwdata[15:0];
          end
        end
        dmdu_pkg::CMD_ADDR: begin
          base_addr_next[chan_reg] = hwdata[19:0];
          if (~base_only_reg) begin
            cur_addr_next[chan_reg] = hwdata[19:0];
          end
        end
        dmdu_pkg::CMD_DEVCTL: bus_hold_next = hwdata[0];
        dmdu_pkg::CMD_MODE: mode_next[chan_reg] = {hwdata[5:2], hwdata[0]};
        dmdu_pkg::CMD_MASK: mask_next = hwdata[3:0];
        default: ;
      endcase
    end
    if (dsel_leg & wr_reg) begin
      if (~cmd[3]) begin
        if (cmd[0]) begin
          base_cnt_next[lch] = hwdata[15:0];
          cur_cnt_next[lch] = hwdata[15:0];
        end else begin
          base_addr_next[lch] = hwdata[19:0];
          cur_addr_next[lch] = hwdata[19:0];
        end
      end else begin
        case (cmd)
          dmdu_pkg::LCMD_REQ: swreq_next[dch] = hwdata[dmdu_pkg::REQ_SET_BIT];
          // the word bit stays as it was, unused here
          dmdu_pkg::LCMD_MODE: mode_next[dch] = {hwdata[5:2], mode_reg[dch].word};
          dmdu_pkg::LCMD_MASK: mask_next = hwdata[3:0];
          default: ;
        endcase
      end
    end
    if (init_cmd) begin
      chan_next = 2'h0;
      base_only_next = 1'b0;
      bus_hold_next = 1'b0;
      tcflag_next = 4'h0;
      mask_next = dmdu_pkg::MASK_RST;
      for (int i = 0; i < 4; i++) begin
        mode_next[i] = 5'h00;
      end
    end
    if (xfer_end) begin
      cur_cnt_next[act_reg] = cur_cnt_reg[act_reg] - 16'h0001;
      cur_addr_next[act_reg] = mode_reg[act_reg].decrement ? cur_addr_reg[act_reg] - step
                                                           : cur_addr_reg[act_reg] + step;
      if (last_xfer) begin
        // hardware set wins over a same-cycle status read
        tcflag_next = tcflag_next | act_oh;
        swreq_next = swreq_next & ~act_oh;
        if (mode_reg[act_reg].autoinit) begin
          cur_cnt_next[act_reg] = base_cnt_reg[act_reg];
          cur_addr_next[act_reg] = base_addr_reg[act_reg];
        end else begin
          mask_next = mask_next | act_oh;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sysctl_reg <= dmdu_pkg::SYSCTL_RST;
      chan_reg <= 2'h0;
      base_only_reg <= 1'b0;
      bus_hold_reg <= 1'b0;
      tcflag_reg <= 4'h0;
      mask_reg <= dmdu_pkg::MASK_RST;
      swreq_reg <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        base_addr_reg[i] <= 20'h00000;
        cur_addr_reg[i] <= 20'h00000;
        base_cnt_reg[i] <= 16'h0000;
        cur_cnt_reg[i] <= 16'h0000;
        mode_reg[i] <= 5'h00;
      end
    end else begin
      sysctl_reg <= sysctl_next;
      chan_reg <= chan_next;
      base_only_reg <= base_only_next;
      bus_hold_reg <= bus_hold_next;
      tcflag_reg <= tcflag_next;
      mask_reg <= mask_next;
      swreq_reg <= swreq_next;
      for (int i = 0; i < 4; i++) begin
        base_addr_reg[i] <= base_addr_next[i];
        cur_addr_reg[i] <= cur_addr_next[i];
        base_cnt_reg[i] <= base_cnt_next[i];
        cur_cnt_reg[i] <= cur_cnt_next[i];
        mode_reg[i] <= mode_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // transfer engine
  // ----------------------------------------------------------------
  logic internal_bus_request_reg, internal_bus_request_next;
  logic [3:0] ackn_reg, ackn_next;
  logic tcn_reg, tcn_next;
  logic [19:0] maddr_reg, maddr_next;
  logic word_reg, word_next;
  dmdu_pkg::dmdu_strobe_s strb_reg, strb_next;
  logic [3:0] valid;
  logic [1:0] win;

  wire [3:0] ch_en = {sysctl_reg[dmdu_pkg::SC_CH3_EN_BIT], dmdu_pkg::CH_ENABLE_LOW3[2:0]};
  wire release_bus = legacy | ~bus_hold_reg;
  wire io_to_mem = (mode_reg[act_reg].dir == dmdu_pkg::DIR_IO_TO_MEM);
  wire mem_to_io = (mode_reg[act_reg].dir == dmdu_pkg::DIR_MEM_TO_IO);
  assign last_xfer = (cur_cnt_reg[act_reg] == 16'h0000);
  assign xfer_end = (st_reg == dmdu_pkg::ST_T4);

  always_comb begin
    // software requests only count in legacy mode
    valid = (sample_reg | (legacy ? swreq_reg : 4'h0)) & ~mask_reg & ch_en;
    win = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (valid[i]) begin
        win = i[1:0];
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    sample_next = sample_reg;
    internal_bus_request_next = internal_bus_request_reg;
    act_next = act_reg;
    case (st_reg)
      dmdu_pkg::ST_IDLE: begin
        sample_next = req_pins;
        internal_bus_request_next = |valid;
        // another master owns the bus until the grant comes back
        if (internal_bus_request_reg & internal_bus_grant & ~acc & (|valid)) begin
          act_next = win;
          st_next = dmdu_pkg::ST_T1;
        end
      end
      dmdu_pkg::ST_T1: st_next = refresh_request ? dmdu_pkg::ST_RWAIT : dmdu_pkg::ST_T2;
      dmdu_pkg::ST_RWAIT: begin
        if (~refresh_request & internal_bus_grant) begin
          st_next = dmdu_pkg::ST_T2;
        end
      end
      dmdu_pkg::ST_T2: st_next = dmdu_pkg::ST_T3;
      // external ready stretches the cycle after the third state
      dmdu_pkg::ST_T3: st_next = ready_pin ? dmdu_pkg::ST_T4 : dmdu_pkg::ST_TW;
      dmdu_pkg::ST_TW: st_next = ready_pin ? dmdu_pkg::ST_T4 : dmdu_pkg::ST_TW;
      dmdu_pkg::ST_T4: begin
        if (last_xfer | release_bus | ~valid[act_reg]) begin
          st_next = dmdu_pkg::ST_IDLE;
          internal_bus_request_next = 1'b0;
        end else begin
          st_next = dmdu_pkg::ST_T1;
        end
      end
      default: st_next = dmdu_pkg::ST_IDLE;
    endcase
  end

  wire nx_busy = (st_next != dmdu_pkg::ST_IDLE);
  wire nx_rd = (st_next == dmdu_pkg::ST_T2) | (st_next == dmdu_pkg::ST_T3) |
               (st_next == dmdu_pkg::ST_TW) | (st_next == dmdu_pkg::ST_T4);
  wire nx_wr = (st_next == dmdu_pkg::ST_T3) | (st_next == dmdu_pkg::ST_TW) | (st_next == dmdu_pkg::ST_T4);

  always_comb begin
    ackn_next = nx_busy ? ~(4'h1 << act_next) : 4'hF;
    tcn_next = ~(nx_wr & (cur_cnt_reg[act_next] == 16'h0000));
    // next-value address so a held bus starts its next transfer on the stepped address
    maddr_next = nx_busy ? cur_addr_next[act_next] : maddr_reg;
    word_next = nx_busy & mode_reg[act_next].word & ~legacy;
    strb_next = dmdu_pkg::STROBE_IDLE;
    if (mode_reg[act_next].dir == dmdu_pkg::DIR_IO_TO_MEM) begin
      strb_next.io_read_strobe_n = ~nx_rd;
      strb_next.memory_write_strobe_n = ~nx_wr;
    end else if (mode_reg[act_next].dir == dmdu_pkg::DIR_MEM_TO_IO) begin
      strb_next.memory_read_strobe_n = ~nx_rd;
      strb_next.io_write_strobe_n = ~nx_wr;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_reg <= dmdu_pkg::ST_IDLE;
      sample_reg <= 4'h0;
      internal_bus_request_reg <= 1'b0;
      act_reg <= 2'h0;
      ackn_reg <= 4'hF;
      tcn_reg <= 1'b1;
      maddr_reg <= 20'h00000;
      word_reg <= 1'b0;
      strb_reg <= dmdu_pkg::STROBE_IDLE;
    end else begin
      st_reg <= st_next;
      sample_reg <= sample_next;
      internal_bus_request_reg <= internal_bus_request_next;
      act_reg <= act_next;
      ackn_reg <= ackn_next;
      tcn_reg <= tcn_next;
      maddr_reg <= maddr_next;
      word_reg <= word_next;
      strb_reg <= strb_next;
    end
  end

  assign internal_bus_request = internal_bus_request_reg;
  assign channel_acknowledge_out_n = ackn_reg;
  assign terminal_count_out_n = tcn_reg;
  assign mem_address_out = maddr_reg;
  assign word_transfer_out = word_reg;
  assign strobes = strb_reg;
endmodule : dmdu_top

// ==== verification/dmdu_checker.sv ====
`timescale 1ns/1ps
module dmdu_checker (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [3:0] channel_acknowledge_out_n,
  input wire logic internal_bus_request,
  input wire logic internal_bus_grant,
  input wire logic terminal_count_out_n,
  input wire dmdu_pkg::dmdu_strobe_s strobes
);
  // ------
  // port relations
  // ------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  wire idle = &channel_acknowledge_out_n;
  a_grant_first: assert property ($fell(idle) |-> $past(internal_bus_grant))
    else $error("ack without grant");
  a_req_first: assert property ($fell(idle) |-> $past(internal_bus_request))
    else $error("ack without bus request");
  a_ack_onehot: assert property (!idle |-> $onehot(~channel_acknowledge_out_n))
    else $error("more than one ack");
  a_ack_four: assert property ($fell(idle) |-> !idle [*4])
    else $error("cycle shorter than four clocks");
  a_strobe_pair: assert property (!(!strobes.io_read_strobe_n && !strobes.io_write_strobe_n)
    && !(!strobes.memory_read_strobe_n && !strobes.memory_write_strobe_n)) else $error("strobe clash");
  a_strobe_owner: assert property (strobes != dmdu_pkg::STROBE_IDLE |-> !idle)
    else $error("strobe outside cycle");
  a_tc_hold: assert property ($fell(terminal_count_out_n) |-> !idle
    ##1 (!terminal_count_out_n && $stable(channel_acknowledge_out_n))) else $error("tc or ack moved");
  a_bus_wait: assert property (hsel && hready && htrans[1] && hreadyout
    |=> !hreadyout ##[1:300] hreadyout) else $error("bus answer timing");
  a_prog_idle: assert property ($rose(hreadyout) |-> idle)
    else $error("access done while busy");
  cover property ($fell(idle));
  cover property ($fell(terminal_count_out_n));
  cover property (!strobes.memory_read_strobe_n);
endmodule : dmdu_checker
bind dmdu_top dmdu_checker i_chk (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .channel_acknowledge_out_n(channel_acknowledge_out_n),
  .internal_bus_request(internal_bus_request), .internal_bus_grant(internal_bus_grant),
  .terminal_count_out_n(terminal_count_out_n), .strobes(strobes));

// ==== verification/dmdu_periph.sv ====
`timescale 1ns/1ps
module dmdu_periph (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [3:0] want,
  input wire logic slow,
  input wire logic [3:0] ack_n,
  input wire logic tc_n,
  output logic [3:0] req,
  output logic ready
);
  logic [3:0] done_reg;
  logic [3:0] wcnt;
  always @(posedge sys_clk) begin
    if (srst) begin
      done_reg <= 4'h0;
      wcnt <= 4'h0;
    end else begin
      done_reg <= want & (done_reg | (~ack_n & {4{~tc_n}}));
      wcnt <= (&ack_n) ? 4'h0 : wcnt + 4'h1;
    end
  end
  // level request held until terminal count is seen
  assign req = want & ~done_reg;
  // slow device stretches the cycle past the third state
  assign ready = !(slow && wcnt < 4'h8);
endmodule : dmdu_periph

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  logic sys_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, ibr, tc_n, word, ready, wseen;
  logic [3:0] req, ack_n, sacc, want = 4'h0;
  logic slow = 1'b0, gnt_en = 1'b0, ibg = 1'b0, rf_en = 1'b0, rfsh = 1'b0;
  logic [19:0] maddr, a0;
  dmdu_pkg::dmdu_strobe_s strb;
  int fail_count = 0, compares = 0, n_x = 0, cur = 0, len = 0;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) ibg <= ibr & gnt_en;
  // refresh holds each transfer in bus wait for six cycles after its first state
  always @(posedge sys_clk) rfsh <= rf_en & (cur < 6);
  dmdu_top i_dut (.sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .channel_request_in(req), .channel_acknowledge_out_n(ack_n),
    .ready_in(ready), .internal_bus_request(ibr), .internal_bus_grant(ibg), .refresh_request(rfsh),
    .terminal_count_out_n(tc_n), .strobes(strb), .mem_address_out(maddr), .word_transfer_out(word));
  dmdu_periph i_per (.sys_clk(sys_clk), .srst(srst), .want(want), .slow(slow), .ack_n(ack_n),
    .tc_n(tc_n), .req(req), .ready(ready));
  // ------
  // transfer monitor and bus tasks
  // ------
  always @(negedge sys_clk) begin
    if (ack_n !== 4'hF) begin
      if (cur == 0) begin
        n_x++;
        if (n_x == 1) a0 = maddr;
      end
      cur++;
      sacc = sacc & strb;
      wseen = wseen | word;
    end else if (cur != 0) begin
      len = cur;
      cur = 0;
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task tmo;
    fail_count++;
    $display("Error at %0t: timeout", $time);
    test_done();
  endtask : tmo
  task rdy;
    int n;
    for (n = 0; n < 300; n++) begin
      @(negedge sys_clk);
      q = hrdata;
      if (hreadyout === 1'b1) break;
    end
    if (n == 300) tmo();
    @(posedge sys_clk);
  endtask : rdy
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    `CHK(q, e)
    `CHK(hresp, 1'b0)
  endtask : rd
  task clr;
    n_x = 0;
    sacc = 4'hF;
    wseen = 1'b0;
  endtask : clr
  task run(input logic [3:0] ch, input int e);
    int n;
    want <= ch;
    for (n = 0; n < 3000; n++) begin
      @(posedge sys_clk);
      if (n_x >= e && cur == 0) break;
    end
    if (n == 3000) tmo();
    repeat (30) @(posedge sys_clk);
    want <= 4'h0;
    `CHK(n_x, e)
  endtask : run
  // ------
  // tests
  // ------
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(8'h00, 32'h0);
    rd(8'h7C, 32'hF);
    rd(8'h20, 32'h0);
    $display("test reset done");
    wr(8'h44, 32'h2);
    wr(8'h68, 32'h1);
    wr(8'h44, 32'h1);
    wr(8'h50, 32'h12345);
    wr(8'h48, 32'h2);
    wr(8'h68, 32'h5);
    rd(8'h44, 32'h2);
    wr(8'h44, 32'h5);
    wr(8'h50, 32'h11111);
    rd(8'h50, 32'h11111);
    wr(8'h44, 32'h1);
    rd(8'h50, 32'h12345);
    wr(8'h7C, 32'hD);
    clr();
    want <= 4'h2;
    repeat (20) @(posedge sys_clk);
    `CHK(ibr, 1'b1)
    `CHK(n_x, 0)
    bus(8'h6C, 1'b0, 32'h0);
    `CHK(q[7:4], 4'h2)
    gnt_en <= 1'b1;
    run(4'h2, 3);
    `CHK(a0, 20'h12345)
    `CHK(len, 4)
    `CHK(sacc, 4'h6)
    `CHK(wseen, 1'b1)
    bus(8'h6C, 1'b0, 32'h0);
    `CHK(q[3:0], 4'h2)
    rd(8'h7C, 32'hF);
    $display("test full mode done");
    wr(8'h44, 32'h0);
    wr(8'h48, 32'h0);
    wr(8'h68, 32'h8);
    wr(8'h7C, 32'hE);
    clr();
    slow <= 1'b1;
    run(4'h1, 1);
    slow <= 1'b0;
    `CHK(len > 4, 1'b1)
    `CHK(sacc, 4'h9)
    `CHK(wseen, 1'b0)
    $display("test wait states done");
    wr(8'h00, 32'h1);
    rd(8'h48, 32'h1234B);
    wr(8'h6C, 32'h6);
    wr(8'h50, 32'h100);
    wr(8'h54, 32'h0);
    wr(8'h7C, 32'hB);
    rd(8'h50, 32'h100);
    clr();
    wr(8'h64, 32'h6);
    rf_en <= 1'b1;
    run(4'h0, 1);
    rf_en <= 1'b0;
    `CHK(len, 10)
    `CHK(sacc, 4'h6)
    `CHK(a0, 20'h00100)
    `CHK(wseen, 1'b0)
    wr(8'h00, 32'h3);
    rd(8'hB8, 32'hF);
    wr(8'h00, 32'h0);
    rd(8'h44, 32'h1);
    $display("test legacy mode done");
    clr();
    wr(8'h7C, 32'h7);
    want <= 4'h8;
    repeat (20) @(posedge sys_clk);
    `CHK(ibr, 1'b0)
    wr(8'h00, 32'h4);
    run(4'h8, 1);
    $display("test channel three done");
    test_done();
  end
endmodule : testbench
